// file: logic/dmc_defines.svh
`ifndef DMC_DEFINES_SVH
`define DMC_DEFINES_SVH

// Register word indices (byte address = index * 4)
`define DMC_IDX_CTRL     6'h00
`define DMC_IDX_OPA      6'h01
`define DMC_IDX_OPB      6'h02
`define DMC_IDX_DESIG    6'h03
`define DMC_IDX_BASE     6'h04
`define DMC_IDX_LAST     6'h05
`define DMC_IDX_PTR      6'h06
`define DMC_IDX_RESULT   6'h07
`define DMC_IDX_FLAGS    6'h08
`define DMC_IDX_SPECIAL  6'h09
`define DMC_IDX_IRQ_ST   6'h0a
`define DMC_IDX_IRQ_MASK 6'h0b
// Table window: indices 0x20..0x3f hold 32 words
`define DMC_TBL_SEL      5
// Control fields
`define DMC_CTRL_OP_LO   0
`define DMC_CTRL_COND    2
// Pointer register: indirect enable bit
`define DMC_PTR_IND      16
// Special relay word bit positions
`define DMC_SP_GREATER   5
`define DMC_SP_EQUAL     6
`define DMC_SP_LESS      7
// Block spans minus one
`define DMC_RANGE_SPAN   16'h001f
`define DMC_TABLE_SPAN   16'h000f
// Digit designator limit
`define DMC_DIGIT_MAX    4'h3
// Interrupt status bits
`define DMC_IRQ_DONE     0
`define DMC_IRQ_ERR      1
// Reset values
`define DMC_LAST_RST     16'h00ff
`define DMC_MASK_RST     2'h0

`endif

// file: logic/dmc_digit_unit.sv
// Functional notes
// - Condition false: no move, only the control field is written
// - Condition true: copy one to four digits
// - Consecutive digits, indices wrap past digit 3
// - Bad designator digit: error, no move
// - Bad indirect pointer sets error flag
// - Word compare writes only equal/less/greater and the error flag
// - Exactly one of equal, less, greater
// - Compare flags hold until next affecting op
// - Less flag visible at special bit 07
// - Sixteen inclusive ranges set result bit k
// - Ranges missing the data clear their bit
// - Limit block past area end: error
// - Table match sets bit k on equal
// - Match table past area end: error
`timescale 1ns/1ps
`default_nettype none
`include "dmc_defines.svh"

module dmc_digit_unit #(
  parameter logic [15:0] DM_LAST = 16'h1999
) (
  input  wire logic                 clock_i,
  input  wire logic                 sys_rst_i,
  input  wire dmc_pkg::dmc_avs_req_t avs_req_i,
  output logic [31:0]               avs_readdata_o,
  output logic                      avs_waitrequest_o,
  output logic                      irq_o,
  output dmc_pkg::dmc_flags_t       cond_flags_o,
  output logic [15:0]               result_word_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic is_bcd(input logic [15:0] w);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (w[i*4 +: 4] > 4'h9) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : is_bcd

  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old_w,
                                          input logic [31:0] new_w,
                                          input logic [3:0]  be);
    logic [15:0] r;
    r = old_w;
    if (be[0]) begin
      r[7:0] = new_w[7:0];
    end
    if (be[1]) begin
      r[15:8] = new_w[15:8];
    end
    return r;
  endfunction : merge16

  // Block end check; a carry past 16 bits also counts as out of area
  function automatic logic past_end(input logic [15:0] base,
                                    input logic [15:0] span,
                                    input logic [15:0] last);
    logic [16:0] top;
    top = {1'b0, base} + {1'b0, span};
    return top > {1'b0, last};
  endfunction : past_end

  ////////////////////////////////////////////////////////////////////////////
  // Operation datapaths

  // Digit 3 is free for the caller; only digits 0..2 index
  function automatic logic desig_bad(input logic [15:0] w);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (w[i*4 +: 4] > `DMC_DIGIT_MAX) begin
        bad = 1'b1;
      end
    end
    return bad;
  endfunction : desig_bad

  // Two-bit indices wrap past digit 3 by themselves
  function automatic logic [15:0] digit_move(input logic [15:0] src,
                                             input logic [15:0] dst,
                                             input logic [15:0] desig);
    logic [15:0] r;
    logic [1:0]  s_ix;
    logic [1:0]  d_ix;
    r    = dst;
    s_ix = 2'h0;
    d_ix = 2'h0;
    for (int i = 0; i < 4; i++) begin
      s_ix = desig[1:0] + 2'(i);
      d_ix = desig[9:8] + 2'(i);
      if (2'(i) <= desig[5:4]) begin
        r[d_ix*4 +: 4] = src[s_ix*4 +: 4];
      end
    end
    return r;
  endfunction : digit_move

  // Inverted pairs simply never hit
  function automatic logic [15:0] range_hits(input logic [15:0]       cd,
                                             input logic [31:0][15:0] t);
    logic [15:0] r;
    r = 16'h0000;
    for (int k = 0; k < 16; k++) begin
      r[k] = cd >= t[2*k] && cd <= t[2*k+1];
    end
    return r;
  endfunction : range_hits

  // Several equal table words all set their bits
  function automatic logic [15:0] table_hits(input logic [15:0]       cd,
                                             input logic [31:0][15:0] t);
    logic [15:0] r;
    r = 16'h0000;
    for (int k = 0; k < 16; k++) begin
      r[k] = cd == t[k];
    end
    return r;
  endfunction : table_hits

  ////////////////////////////////////////////////////////////////////////////
  // State

  dmc_pkg::dmc_state_t q;
  dmc_pkg::dmc_state_t d;

  always_comb begin
    logic        acc;
    logic [5:0]  idx;
    logic        err;
    logic [1:0]  ev;
    logic [15:0] tmp;
    logic [15:0] hits;
    acc  = 1'b0;
    idx  = avs_req_i.address;
    err  = 1'b0;
    ev   = 2'h0;
    tmp  = 16'h0000;
    hits = 16'h0000;
    d    = q;

    // One wait cycle, then the answer edge
    d.wait_q = 1'b1;
    if ((avs_req_i.read || avs_req_i.write) && q.wait_q) begin
      d.wait_q = 1'b0;
      d.rdata  = 32'h0000_0000;
      if (idx[`DMC_TBL_SEL]) begin
        d.rdata[15:0] = q.tbl[idx[4:0]];
      end else begin
        case (idx)
          `DMC_IDX_CTRL:     d.rdata[2:0]  = q.ctrl;
          `DMC_IDX_OPA:      d.rdata[15:0] = q.opa;
          `DMC_IDX_OPB:      d.rdata[15:0] = q.opb;
          `DMC_IDX_DESIG:    d.rdata[15:0] = q.desig;
          `DMC_IDX_BASE:     d.rdata[15:0] = q.base;
          `DMC_IDX_LAST:     d.rdata[15:0] = q.last;
          `DMC_IDX_PTR:      d.rdata[16:0] = q.ptr;
          `DMC_IDX_RESULT:   d.rdata[15:0] = q.result;
          `DMC_IDX_FLAGS:    d.rdata[3:0]  = q.flags;
          `DMC_IDX_SPECIAL: begin
            d.rdata[`DMC_SP_GREATER] = q.flags.greater;
            d.rdata[`DMC_SP_EQUAL]   = q.flags.equal;
            d.rdata[`DMC_SP_LESS]    = q.flags.less;
          end
          `DMC_IDX_IRQ_ST:   d.rdata[1:0]  = q.irq_st;
          `DMC_IDX_IRQ_MASK: d.rdata[1:0]  = q.irq_mask;
          default:           d.rdata       = 32'h0000_0000;
        endcase
      end
    end

    // Writes and execution land on the answer edge
    acc = !q.wait_q;
    if (acc && avs_req_i.read && idx == `DMC_IDX_IRQ_ST) begin
      d.irq_st = 2'h0;
    end

    if (acc && avs_req_i.write) begin
      if (idx[`DMC_TBL_SEL]) begin
        d.tbl[idx[4:0]] = merge16(q.tbl[idx[4:0]], avs_req_i.writedata,
                                  avs_req_i.byteenable);
      end else begin
        case (idx)
          `DMC_IDX_OPA:   d.opa   = merge16(q.opa, avs_req_i.writedata,
                                            avs_req_i.byteenable);
          `DMC_IDX_OPB:   d.opb   = merge16(q.opb, avs_req_i.writedata,
                                            avs_req_i.byteenable);
          `DMC_IDX_DESIG: d.desig = merge16(q.desig, avs_req_i.writedata,
                                            avs_req_i.byteenable);
          `DMC_IDX_BASE:  d.base  = merge16(q.base, avs_req_i.writedata,
                                            avs_req_i.byteenable);
          `DMC_IDX_LAST:  d.last  = merge16(q.last, avs_req_i.writedata,
                                            avs_req_i.byteenable);
          `DMC_IDX_PTR: begin
            d.ptr[15:0] = merge16(q.ptr[15:0], avs_req_i.writedata,
                                  avs_req_i.byteenable);
            if (avs_req_i.byteenable[2]) begin
              d.ptr[`DMC_PTR_IND] = avs_req_i.writedata[`DMC_PTR_IND];
            end
          end
          `DMC_IDX_IRQ_MASK: d.irq_mask = avs_req_i.writedata[1:0];
          `DMC_IDX_CTRL: begin
            d.ctrl = avs_req_i.writedata[2:0];
            // Condition false: command is dropped, no event either
            if (avs_req_i.writedata[`DMC_CTRL_COND]) begin
              ev[`DMC_IRQ_DONE] = 1'b1;
              // Bad indirect pointer aborts every operation
              if (q.ptr[`DMC_PTR_IND] &&
                  (!is_bcd(q.ptr[15:0]) || q.ptr[15:0] > DM_LAST)) begin
                err = 1'b1;
              end
              case (dmc_pkg::dmc_op_t'(avs_req_i.writedata[1:0]))
                dmc_pkg::DMC_DIGIT_COPY: begin
                  // relied on only for a meaningful move
                  if (desig_bad(q.desig)) begin
                    err = 1'b1;
                  end
                  tmp = digit_move(q.opa, q.opb, q.desig);
                  if (!err) begin
                    d.opb    = tmp;
                    d.result = tmp;
                  end
                end
                dmc_pkg::DMC_WORD_CMP: begin
                  // relied on: BCD and binary order agree
                  if (!err) begin
                    d.flags.equal   = q.opa == q.opb;
                    d.flags.less    = q.opa <  q.opb;
                    d.flags.greater = q.opa >  q.opb;
                  end
                end
                dmc_pkg::DMC_RANGE_CMP: begin
                  if (past_end(q.base, `DMC_RANGE_SPAN, q.last)) begin
                    err = 1'b1;
                  end
                  // relied on: an inverted pair never hits
                  hits = range_hits(q.opa, q.tbl);
                  if (!err) begin
                    d.result = hits;
                  end
                end
                dmc_pkg::DMC_TABLE_MATCH: begin
                  if (past_end(q.base, `DMC_TABLE_SPAN, q.last)) begin
                    err = 1'b1;
                  end
                  hits = table_hits(q.opa, q.tbl);
                  if (!err) begin
                    d.result = hits;
                  end
                end
                default: d.result = q.result;
              endcase
              d.flags.error      = err;
              ev[`DMC_IRQ_ERR]   = err;
            end
          end
          default: d.ctrl = q.ctrl;
        endcase
      end
    end

    // Events win over a same-cycle read clear
    d.irq_st = d.irq_st | ev;
    d.irq    = |(d.irq_st & d.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Comparison flags only move on an executed compare
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      q          <= '0;
      q.wait_q   <= 1'b1;
      q.last     <= `DMC_LAST_RST;
      q.irq_mask <= `DMC_MASK_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign avs_readdata_o    = q.rdata;
  assign avs_waitrequest_o = q.wait_q;
  assign irq_o             = q.irq;
  assign cond_flags_o      = q.flags;
  assign result_word_o     = q.result;

endmodule : dmc_digit_unit

`default_nettype wire

// file: logic/dmc_pkg.sv
`default_nettype none
package dmc_pkg;

  typedef enum logic [1:0] {
    DMC_DIGIT_COPY  = 2'h0,
    DMC_WORD_CMP    = 2'h1,
    DMC_RANGE_CMP   = 2'h2,
    DMC_TABLE_MATCH = 2'h3
  } dmc_op_t;

  typedef struct packed {
    logic error;
    logic greater;
    logic less;
    logic equal;
  } dmc_flags_t;

  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } dmc_avs_req_t;

  typedef struct packed {
    logic               wait_q;
    logic [31:0]        rdata;
    logic               irq;
    logic [2:0]         ctrl;
    logic [15:0]        opa;
    logic [15:0]        opb;
    logic [15:0]        desig;
    logic [15:0]        base;
    logic [15:0]        last;
    logic [16:0]        ptr;
    logic [15:0]        result;
    dmc_flags_t         flags;
    logic [1:0]         irq_st;
    logic [1:0]         irq_mask;
    logic [31:0][15:0]  tbl;
  } dmc_state_t;

endpackage : dmc_pkg

`default_nettype wire

// file: tb/dmc_digit_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dmc_digit_monitor #(
  parameter logic [15:0] DM_LAST = 16'h1999
) (
  input wire logic                  clock_i,
  input wire logic                  sys_rst_i,
  input wire dmc_pkg::dmc_avs_req_t avs_req_i,
  input wire logic [31:0]           avs_readdata_o,
  input wire logic                  avs_waitrequest_o,
  input wire logic                  irq_o,
  input wire dmc_pkg::dmc_flags_t   cond_flags_o,
  input wire logic [15:0]           result_word_o
);
  logic       tk;
  logic       ctl;
  logic [2:0] cf;
  assign tk = (avs_req_i.read || avs_req_i.write) && avs_waitrequest_o;
  assign ctl = avs_req_i.write && !avs_waitrequest_o && avs_req_i.address == 6'h00;
  assign cf = {cond_flags_o.greater, cond_flags_o.less, cond_flags_o.equal};
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  sequence one_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  ////////////////////////////////////////
  bus_answer_a: assert property (tk |=> one_answer) else $error("bus answer");
  no_stray_a: assert property (!avs_waitrequest_o |-> $past(tk)) else $error("stray answer");
  reset_vals_a: assert property (disable iff (1'b0) sys_rst_i |=> avs_waitrequest_o
    && !irq_o && cond_flags_o == 4'h0 && result_word_o == 16'h0000) else $error("reset");
  excl_flags_a: assert property ($onehot0(cf)) else $error("flags");
  cond_off_a: assert property (ctl && !avs_req_i.writedata[2] |=>
    $stable(cond_flags_o) && $stable(result_word_o)) else $error("cond off");
  flags_hold_a: assert property ($changed(cond_flags_o) |-> $past(ctl))
    else $error("flags moved");
  cmp_only_a: assert property (ctl && avs_req_i.writedata[1:0] == 2'h1
    |=> $stable(result_word_o)) else $error("cmp result");
  result_cause_a: assert property ($changed(result_word_o) |->
    $past(ctl && avs_req_i.writedata[2])) else $error("result moved");
endmodule : dmc_digit_monitor

bind dmc_digit_unit dmc_digit_monitor #(.DM_LAST(DM_LAST)) u_mon (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .avs_req_i(avs_req_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .irq_o(irq_o), .cond_flags_o(cond_flags_o), .result_word_o(result_word_o)
);
`default_nettype wire

// file: tb/dmc_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmc_seq_model (
  input  wire logic                  clock_i,
  input  wire logic                  wait_i,
  output var  dmc_pkg::dmc_avs_req_t req_o
);
  initial req_o = '0;
  // One idle edge first, so strobes never toggle twice in a step
  task automatic xfer(input logic rd, input logic [5:0] i, input logic [31:0] d,
                      input logic [3:0] be);
    @(posedge clock_i);
    req_o <= '{i, rd, !rd, d, be};
    do @(posedge clock_i); while (wait_i !== 1'b0);
    req_o <= '0;
  endtask : xfer
endmodule : dmc_seq_model
`default_nettype wire

// file: tb/tb_digit_move_and_compare_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_digit_move_and_compare_unit;
  logic                  clock_i = 1'b0;
  logic                  sys_rst_i = 1'b1;
  dmc_pkg::dmc_avs_req_t req;
  logic [31:0]           rdata;
  logic                  waitr;
  logic                  irq;
  int                    n_mismatch = 0;
  int                    num_checks = 0;
  logic [15:0]           exp_q[$];
  logic [15:0]           lf = 16'h0035;
  logic [15:0]           tbl[32];
  logic [15:0]           a;
  logic [15:0]           b;
  logic [15:0]           r;
  logic [15:0]           ex;
  logic [15:0]           res;
  dmc_pkg::dmc_flags_t   flg;
  logic [15:0]           cds[5] = '{16'h0210, 16'h0300, 16'h0301, 16'h1000, 16'h1001};

  initial forever #4 clock_i = ~clock_i;
  dmc_seq_model seq (.clock_i(clock_i), .wait_i(waitr), .req_o(req));
  dmc_digit_unit dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .avs_req_i(req),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitr), .irq_o(irq),
    .cond_flags_o(flg), .result_word_o(res));
  ////////////////////////////////////////
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction : rnd
  function automatic logic [15:0] dcopy(input logic [15:0] s, d, input int k);
    logic [15:0] o;
    o = d;
    for (int i = 0; i <= k[3:2]; i++) begin
      o[((k[5:4] + i) % 4) * 4 +: 4] = s[((k[1:0] + i) % 4) * 4 +: 4];
    end
    return o;
  endfunction : dcopy
  function automatic logic [15:0] hits(input logic [15:0] cd, input logic rng);
    logic [15:0] o;
    for (int k = 0; k < 16; k++) o[k] = rng ? tbl[2*k] <= cd && cd <= tbl[2*k+1] : tbl[k] == cd;
    return o;
  endfunction : hits
  task automatic chk(input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic wr(input logic [5:0] i, input logic [16:0] d);
    seq.xfer(1'b0, i, {15'h0, d}, 4'hf);
  endtask : wr
  task automatic rd(input logic [5:0] i, input logic [15:0] e);
    exp_q.push_back(e);
    seq.xfer(1'b1, i, 32'h0, 4'hf);
  endtask : rd
  task automatic op(input logic [2:0] c, input logic [5:0] i, input logic [15:0] e);
    wr(6'h00, {14'h0, c});
    rd(i, e);
  endtask : op
  // Two edges of margin: status and the registered level land on the same edge
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clock_i);
    #1 chk({31'h0, e}, {31'h0, irq});
  endtask : irq_is
  task test_done;
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  ////////////////////////////////////////
  always @(posedge clock_i) begin
    if (req.read === 1'b1 && waitr === 1'b0) begin
      ex = exp_q.pop_front();
      chk({16'h0, ex}, rdata);
      if (req.address == 6'h07) chk({16'h0, ex}, {16'h0, res});
      if (req.address == 6'h08) chk({16'h0, ex}, {28'h0, flg});
    end
  end
  initial begin
    repeat (5000) @(posedge clock_i);
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rd(6'h05, 16'h00ff);
    rd(6'h0a, 16'h0000);
    wr(6'h0c, 16'hffff);
    rd(6'h0c, 16'h0000);
    seq.xfer(1'b0, 6'h01, 32'h0000_abcd, 4'h2);
    rd(6'h01, 16'hab00);
    wr(6'h01, 16'h0005);
    wr(6'h02, 16'h0005);
    wr(6'h00, 16'h0005);
    irq_is(1'b0);
    rd(6'h0a, 16'h0001);
    rd(6'h0a, 16'h0000);
    wr(6'h0b, 16'h0001);
    wr(6'h00, 16'h0005);
    irq_is(1'b1);
    rd(6'h0a, 16'h0001);
    irq_is(1'b0);
    for (int i = 0; i < 3; i++) begin
      a = (rnd() & 16'h7ff0) | 16'h0008;
      b = (i == 2) ? a - 16'h1 : a + 16'(i);
      wr(6'h01, a);
      wr(6'h02, b);
      op(3'h5, 6'h08, 16'(1 << i));
      rd(6'h09, (i == 2) ? 16'h0020 : 16'h0040 << i);
    end
    // Every designator, with a random ignored top digit
    for (int k = 0; k < 64; k++) begin
      a = rnd();
      b = rnd();
      wr(6'h01, a);
      wr(6'h02, b);
      wr(6'h03, (rnd() & 16'hf000) | {6'h0, 2'(k >> 4), 2'h0, 2'(k >> 2), 2'h0, 2'(k)});
      r = dcopy(a, b, k);
      op(3'h4, 6'h07, r);
    end
    rd(6'h08, 16'h0004);
    wr(6'h01, 16'h0000);
    op(3'h0, 6'h07, r);
    op(3'h1, 6'h08, 16'h0004);
    for (int i = 0; i < 3; i++) begin
      wr(6'h03, 16'h0004 << (4 * i));
      op(3'h4, 6'h08, 16'h000c);
      rd(6'h07, r);
    end
    wr(6'h06, 17'h100a0);
    op(3'h5, 6'h08, 16'h000c);
    wr(6'h06, 17'h12000);
    op(3'h5, 6'h08, 16'h000c);
    wr(6'h06, 17'h00000);
    for (int k = 0; k < 32; k++) begin
      tbl[k] = k[0] ? 16'((k / 2 + 1) * 256) : 16'((k == 0) ? 0 : k / 2 * 256 + 1);
      wr(6'(32 + k), tbl[k]);
    end
    for (int i = 0; i < 5; i++) begin
      wr(6'h01, cds[i]);
      op(3'h6, 6'h07, hits(cds[i], 1'b1));
    end
    wr(6'h04, 16'h00e1);
    op(3'h6, 6'h08, 16'h000c);
    for (int k = 0; k < 16; k++) begin
      tbl[k] = (k == 3 || k == 9) ? 16'h0777 : rnd();
      wr(6'(32 + k), tbl[k]);
    end
    wr(6'h04, 16'h0000);
    wr(6'h01, 16'h0777);
    op(3'h7, 6'h07, hits(16'h0777, 1'b0));
    wr(6'h04, 16'h00f1);
    op(3'h7, 6'h08, 16'h000c);
    wr(6'h04, 16'h00f0);
    op(3'h7, 6'h08, 16'h0004);
    test_done();
  end
endmodule : tb_digit_move_and_compare_unit
`default_nettype wire
